// file: common/eagen_pkg.sv
// Functional notes
// - Two-word form: bits 15-16 pick procedure, stack, link or auxiliary base.
// - Second word is a 16-bit displacement added to the chosen base.
// - I, X, Y and base select give 32 distinct address computations.
// - Two-word indirect pointers are always fetched as two words, 32-bit or 48-bit format alike.
// - Two-word final address is always memory, never a register.
// - I, X, Y all zero: base plus displacement, no index, no indirection.
// - Only Y set adds Y index; only X set adds X index.
// - I clear, X and Y set: pointer at base plus displacement, unindexed.
// - I set, Y clear: index added before reading the pointer.
// - I set, Y set: pointer read first, then index added.
// - Load and store index instructions allow only direct or indirect forms.
// - 16K mode: 14-bit addresses; indirect word has I, X and 14-bit address.
// - 16K mode: repeated indexing, index applied before each indirection.
// - Sectored modes use program counter of the instruction itself.
// - Sector bit clear: sector bits forced to zero, displacement in sector zero.
// - Sector bit set: program counter sector bits joined with displacement.
// - Sector bit clear, I and X clear, displacement 0 to 7: access goes to a register.
// - 32K mode: 15-bit addresses; indirect word has 15-bit address, no X.
// - 32K mode: multi-level indirection, one indexing after all indirection.
// - 32K, I and X set, S clear: D under 100 octal preindexed, else postindexed.
package eagen_pkg;
    // Modes
    localparam logic [1:0] MODE_S16K = 2'h0;
    localparam logic [1:0] MODE_S32K = 2'h1;
    localparam logic [1:0] MODE_V64K = 2'h2;
    // Base select codes
    localparam logic [1:0] BASE_PROC = 2'h0;
    localparam logic [1:0] BASE_STACK = 2'h1;
    localparam logic [1:0] BASE_LINK = 2'h2;
    localparam logic [1:0] BASE_AUX = 2'h3;
    // First-word field positions, LSB numbering (bit n = 16 - index)
    localparam int FW_IND = 15;
    localparam int FW_XB = 14;
    localparam int FW_YB = 4;
    localparam int FW_SECT = 9;
    localparam int FW_BR_HI = 1;
    // Field widths
    localparam int DISP9_W = 9;
    localparam int ADDR14_W = 14;
    localparam int ADDR15_W = 15;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 32;
    // Register alias and preindex limits
    localparam logic [8:0] REG_ALIAS_MAX = 9'h007;
    localparam logic [8:0] PREIDX_MAX = 9'h03F;
endpackage

// file: src/ea_select.sv
`timescale 1ns/1ps
`default_nettype none
module ea_select (
    // Select
    input wire logic [1:0] sel_i,
    // Bases
    input wire logic [31:0] procedure_base_i,
    input wire logic [31:0] stack_base_i,
    input wire logic [31:0] link_base_i,
    input wire logic [31:0] auxiliary_base_i,
    // Result
    output logic [31:0] base_o
);
    always_comb
    begin
        case (sel_i)
            eagen_pkg::BASE_PROC: base_o = procedure_base_i;
            eagen_pkg::BASE_STACK: base_o = stack_base_i;
            eagen_pkg::BASE_LINK: base_o = link_base_i;
            default: base_o = auxiliary_base_i;
        endcase
    end
endmodule
`default_nettype wire

// file: src/sector_form.sv
`timescale 1ns/1ps
`default_nettype none
module sector_form (
    // Inputs
    input wire logic sect_i,
    input wire logic [8:0] disp_i,
    input wire logic [15:0] pc_i,
    // Result
    output logic [15:0] addr_o,
    output logic reg_alias_o
);
    always_comb
    begin
        if (sect_i)
        begin
            addr_o = {pc_i[15:9], disp_i};
        end
        else
        begin
            addr_o = {7'h00, disp_i};
        end
    end
    assign reg_alias_o = !sect_i && (disp_i <= eagen_pkg::REG_ALIAS_MAX);
endmodule
`default_nettype wire

// file: src/effective_address_generator.sv
`timescale 1ns/1ps
`default_nettype none
module effective_address_generator (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Request from decoder
    input wire logic start_i,
    input wire logic [1:0] mode_i,
    input wire logic [15:0] word1_i,
    input wire logic [15:0] word2_i,
    input wire logic index_instr_i,
    input wire logic long_ptr_i,
    input wire logic [15:0] pc_i,
    // Machine registers
    input wire logic [31:0] procedure_base_i,
    input wire logic [31:0] stack_base_i,
    input wire logic [31:0] link_base_i,
    input wire logic [31:0] auxiliary_base_i,
    input wire logic [15:0] x_index_i,
    input wire logic [15:0] y_index_i,
    // Memory read port
    output logic rd_req_o,
    output logic [31:0] rd_addr_o,
    input wire logic rd_ack_i,
    input wire logic [15:0] rd_data_i,
    // Result
    output logic busy_o,
    output logic done_o,
    output logic [31:0] ea_o,
    output logic ea_is_reg_o,
    output logic illegal_o
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_READ2 = 4'h4,
        ST_DONE = 4'h8
    } state_t;

    state_t state_q;
    logic [1:0] mode_q;
    logic post_x_q;
    logic post_y_q;
    logic second_q;
    logic long_q;
    logic [15:0] hi_q;
    logic [15:0] x_q;
    logic [15:0] y_q;
    logic [31:0] addr_q;
    logic [31:0] base_sel;
    logic [15:0] sect_addr;
    logic sect_reg;
    logic ind;
    logic xb;
    logic yb;
    logic sect;
    logic [8:0] disp;

    function automatic logic [31:0] add16(input logic [31:0] a, input logic [15:0] b);
        add16 = a + {16'h0000, b};
    endfunction

    assign ind = word1_i[eagen_pkg::FW_IND];
    assign xb = word1_i[eagen_pkg::FW_XB];
    assign yb = word1_i[eagen_pkg::FW_YB];
    assign sect = word1_i[eagen_pkg::FW_SECT];
    assign disp = word1_i[eagen_pkg::DISP9_W-1:0];

    ea_select u_sel (
        .sel_i(word1_i[eagen_pkg::FW_BR_HI:0]),
        .procedure_base_i(procedure_base_i),
        .stack_base_i(stack_base_i),
        .link_base_i(link_base_i),
        .auxiliary_base_i(auxiliary_base_i),
        .base_o(base_sel)
    );

    sector_form u_sect (
        .sect_i(sect),
        .disp_i(disp),
        .pc_i(pc_i),
        .addr_o(sect_addr),
        .reg_alias_o(sect_reg)
    );

    ////////////////////////////////////////////////////////////////////////
    // Start decode
    logic [31:0] st_addr;
    logic st_ind;
    logic st_px;
    logic st_py;
    logic st_reg;
    logic st_ill;
    logic [31:0] bd;
    always_comb
    begin
        bd = add16(base_sel, word2_i);
        st_addr = bd;
        st_ind = 1'b0;
        st_px = 1'b0;
        st_py = 1'b0;
        st_reg = 1'b0;
        st_ill = 1'b0;
        case (mode_i)
            eagen_pkg::MODE_V64K:
            begin
                // 32 combinations of I, X, Y and base select
                case ({ind, xb, yb})
                    3'h0: st_addr = bd;
                    3'h1: st_addr = add16(bd, y_index_i);
                    3'h2: st_addr = add16(bd, x_index_i);
                    3'h3: st_ind = 1'b1;
                    3'h4:
                    begin
                        st_addr = add16(bd, y_index_i);
                        st_ind = 1'b1;
                    end
                    3'h5:
                    begin
                        st_ind = 1'b1;
                        st_py = 1'b1;
                    end
                    3'h6:
                    begin
                        st_addr = add16(bd, x_index_i);
                        st_ind = 1'b1;
                    end
                    default:
                    begin
                        st_ind = 1'b1;
                        st_px = 1'b1;
                    end
                endcase
                st_ill = index_instr_i && !({ind, xb, yb} == 3'h0 || {ind, xb, yb} == 3'h3);
            end
            eagen_pkg::MODE_S16K:
            begin
                st_addr = {18'h00000, (xb ? sect_addr[13:0] + x_index_i[13:0]
                                          : sect_addr[13:0])};
                st_ind = ind;
                st_reg = sect_reg && !xb && !ind;
            end
            default:
            begin
                st_ind = ind;
                st_reg = sect_reg && !xb && !ind;
                if (xb && ind && (sect || disp > eagen_pkg::PREIDX_MAX))
                begin
                    st_addr = {17'h00000, sect_addr[14:0]};
                    st_px = 1'b1;
                end
                else
                begin
                    st_addr = {17'h00000, (xb ? sect_addr[14:0] + x_index_i[14:0]
                                              : sect_addr[14:0])};
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (start_i)
                    begin
                        state_q <= (st_ind && !st_ill) ? ST_READ : ST_DONE;
                    end
                ST_READ:
                    if (rd_ack_i)
                    begin
                        if (mode_q == eagen_pkg::MODE_V64K)
                        begin
                            state_q <= ST_READ2;
                        end
                        else if (!rd_data_i[eagen_pkg::FW_IND])
                        begin
                            state_q <= ST_DONE;
                        end
                    end
                ST_READ2:
                    if (rd_ack_i && !long_q)
                    begin
                        state_q <= ST_DONE;
                    end
                    else if (rd_ack_i)
                    begin
                        state_q <= ST_DONE;
                    end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address datapath
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            addr_q <= 32'h00000000;
            mode_q <= 2'h0;
            post_x_q <= 1'b0;
            post_y_q <= 1'b0;
            long_q <= 1'b0;
            hi_q <= 16'h0000;
            x_q <= 16'h0000;
            y_q <= 16'h0000;
            ea_is_reg_o <= 1'b0;
            illegal_o <= 1'b0;
        end
        else if (state_q == ST_IDLE && start_i)
        begin
            addr_q <= st_addr;
            mode_q <= mode_i;
            post_x_q <= st_px;
            post_y_q <= st_py;
            long_q <= long_ptr_i;
            x_q <= x_index_i;
            y_q <= y_index_i;
            ea_is_reg_o <= st_reg;
            illegal_o <= st_ill;
        end
        else if (state_q == ST_READ && rd_ack_i)
        begin
            if (mode_q == eagen_pkg::MODE_V64K)
            begin
                hi_q <= rd_data_i;
                addr_q <= add16(addr_q, 16'h0001);
            end
            else if (mode_q == eagen_pkg::MODE_S16K)
            begin
                addr_q <= {18'h00000, (rd_data_i[eagen_pkg::FW_XB]
                    ? rd_data_i[13:0] + x_q[13:0] : rd_data_i[13:0])};
            end
            else if (!rd_data_i[eagen_pkg::FW_IND] && post_x_q)
            begin
                addr_q <= {17'h00000, rd_data_i[14:0] + x_q[14:0]};
            end
            else
            begin
                addr_q <= {17'h00000, rd_data_i[14:0]};
            end
        end
        else if (state_q == ST_READ2 && rd_ack_i)
        begin
            // 32-bit and 48-bit forms alike: offset from second word read; segment from first word
            addr_q <= post_x_q ? add16({hi_q, rd_data_i}, x_q)
                    : post_y_q ? add16({hi_q, rd_data_i}, y_q)
                    : {hi_q, rd_data_i};
        end
    end

    assign rd_req_o = (state_q == ST_READ) || (state_q == ST_READ2);
    assign rd_addr_o = addr_q;
    assign busy_o = state_q != ST_IDLE;
    assign done_o = state_q == ST_DONE;
    assign ea_o = addr_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_start_v_direct;
        start_i && state_q == ST_IDLE && mode_i == eagen_pkg::MODE_V64K
            && {ind, xb, yb} == 3'h0;
    endsequence
    chk_v_direct_sum: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        s_start_v_direct |=> done_o && ea_o == $past(bd))
        else $error("direct sum wrong");
    chk_v_never_reg: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        done_o && mode_q == eagen_pkg::MODE_V64K |-> !ea_is_reg_o)
        else $error("virtual address aliased to register");
    chk_v_y_index: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        start_i && state_q == ST_IDLE && mode_i == eagen_pkg::MODE_V64K
        && {ind, xb, yb} == 3'h1 |=> ea_o == $past(bd) + {16'h0000, $past(y_index_i)})
        else $error("y index wrong");
    chk_v_ind_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        start_i && state_q == ST_IDLE && mode_i == eagen_pkg::MODE_V64K
        && {ind, xb, yb} == 3'h3 && !index_instr_i |=> rd_req_o && rd_addr_o == $past(bd))
        else $error("pointer read address wrong");
    chk_v_two_reads: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        state_q == ST_READ && rd_ack_i && mode_q == eagen_pkg::MODE_V64K |=> state_q == ST_READ2)
        else $error("pointer not two words");
    chk_index_instr_ill: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        start_i && state_q == ST_IDLE && mode_i == eagen_pkg::MODE_V64K && index_instr_i
        && {ind, xb, yb} == 3'h1 |=> illegal_o && done_o)
        else $error("indexed load index not refused");
    chk_sect_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        start_i && state_q == ST_IDLE && mode_i != eagen_pkg::MODE_V64K && !sect && !ind
        && !xb |=> ea_o[15:9] == 7'h00)
        else $error("sector bits not zero");
    chk_reg_alias: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        start_i && state_q == ST_IDLE && mode_i != eagen_pkg::MODE_V64K && !sect && !ind
        && !xb && disp <= eagen_pkg::REG_ALIAS_MAX |=> ea_is_reg_o)
        else $error("register alias missed");
    chk_chain_stop: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        state_q == ST_READ && rd_ack_i && mode_q != eagen_pkg::MODE_V64K
        && !rd_data_i[eagen_pkg::FW_IND] |=> done_o ##1 !busy_o)
        else $error("chain did not stop");
endmodule
`default_nettype wire

// file: tb/ea_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ea_mem_model (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Read port
    input wire logic rd_req_i,
    input wire logic [31:0] rd_addr_i,
    input wire logic slow_i,
    output logic rd_ack_o,
    output logic [15:0] rd_data_o
);
    logic [15:0] mem [0:127];
    logic [1:0] wait_q;
    ////////////////////////////////////////////////////////////////////////////////
    // One-cycle ack after zero or three idle cycles; data scrambled off ack
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i || !rd_req_i || rd_ack_o)
        begin
            rd_ack_o <= 1'b0;
            wait_q <= slow_i ? 2'h3 : 2'h0;
            rd_data_o <= sys_rst_i ? 16'h5A5A : ~rd_data_o;
        end
        else if (wait_q != 2'h0)
        begin
            wait_q <= wait_q - 2'h1;
            rd_data_o <= ~rd_data_o;
        end
        else
        begin
            rd_ack_o <= 1'b1;
            rd_data_o <= mem[rd_addr_i[6:0]];
        end
    end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {logic [31:0] ea; logic is_reg; logic ill;} exp_t;
    logic clk, rst, start, idx, lp, slow, rd_req, rd_ack, busy, done, ea_reg, ill;
    logic [1:0] mode;
    logic [15:0] w1, w2, pc, xi, yi, rd_data;
    logic [31:0] pb, sb, lb, ab, rd_addr, ea;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    exp_t exp_q[$];
    logic [31:0] rd_q[$];
    effective_address_generator effective_address_generator_i (.clk_sys_i(clk), .sys_rst_i(rst),
        .start_i(start), .mode_i(mode), .word1_i(w1), .word2_i(w2), .index_instr_i(idx),
        .long_ptr_i(lp), .pc_i(pc), .procedure_base_i(pb), .stack_base_i(sb),
        .link_base_i(lb), .auxiliary_base_i(ab), .x_index_i(xi), .y_index_i(yi),
        .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_ack_i(rd_ack), .rd_data_i(rd_data),
        .busy_o(busy), .done_o(done), .ea_o(ea), .ea_is_reg_o(ea_reg), .illegal_o(ill));
    ea_mem_model ea_mem_model_i (.clk_sys_i(clk), .sys_rst_i(rst), .rd_req_i(rd_req),
        .rd_addr_i(rd_addr), .slow_i(slow), .rd_ack_o(rd_ack), .rd_data_o(rd_data));
    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    function automatic logic [15:0] vw1(input logic i, x, y, input logic [1:0] br);
        return {i, x, 4'h0, 5'h18, y, 2'h0, br};
    endfunction
    function automatic logic [15:0] sw1(input logic i, x, s, input logic [8:0] d);
        return {i, x, 4'h0, s, d};
    endfunction
    function automatic logic [31:0] ptr(input logic [31:0] a);
        return {ea_mem_model_i.mem[a[6:0]], ea_mem_model_i.mem[7'(a + 32'h1)]};
    endfunction
    task automatic tally_and_finish();
        $display("Counts: %0d checked, %0d errors", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic fail(input string s);
        err_total++;
        $display("ERROR %0t %s", $time, s);
    endtask
    task automatic check(input bit ok, input string s);
        samples_checked++;
        if (!ok)
            fail(s);
    endtask
    task automatic cmp_res();
        exp_t e;
        if (exp_q.size() == 0)
            fail("result with no note");
        else
        begin
            e = exp_q.pop_front();
            check(ill === e.ill && (e.ill || (ea === e.ea && ea_reg === e.is_reg)), "result");
        end
    endtask
    task automatic cmp_rd();
        if (rd_q.size() == 0)
            fail("read with no note");
        else
            check(rd_addr === rd_q.pop_front(), "read address");
    endtask
    task automatic run(input logic [1:0] m, input logic [15:0] a, b, input logic ix,
        input exp_t e);
        int n;
        exp_q.push_back(e);
        mode = m;
        w1 = a;
        w2 = b;
        idx = ix;
        start = 1'b1;
        @(posedge clk) #1;
        start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 60)
        begin
            @(posedge clk) #1;
            n++;
        end
        if (done !== 1'b1)
            fail("no result in time");
        @(posedge clk) #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, monitor and timeout
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(negedge clk)
    begin
        if (done === 1'b1)
            cmp_res();
        if (rd_req === 1'b1 && rd_ack === 1'b1)
            cmp_rd();
        cycles++;
        if (cycles == 5000)
        begin
            fail("timeout");
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [31:0] seed, b, a, x;
        logic [15:0] d;
        logic [2:0] c;
        logic ind;
        seed = 32'h57500EE7;
        {rst, start, idx, lp, slow, mode, w1, w2, pc} = '0;
        {pb, sb, lb, ab, xi, yi} = '0;
        rst = 1'b1;
        for (int i = 0; i < 128; i++)
            ea_mem_model_i.mem[i] = 16'h0200 + 16'(i);
        ea_mem_model_i.mem[7'h2A] = 16'hC030;
        ea_mem_model_i.mem[7'h3A] = 16'h0155;
        ea_mem_model_i.mem[7'h49] = 16'h0123;
        ea_mem_model_i.mem[7'h40] = 16'h0150;
        ea_mem_model_i.mem[7'h44] = 16'h8046;
        ea_mem_model_i.mem[7'h46] = 16'h0077;
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        check(busy === 1'b0 && done === 1'b0 && rd_req === 1'b0 && ea === 32'h0, "reset");
        $display("test reset done");
        for (int k = 0; k < 12; k++)
        begin
            seed = lfsr(seed);
            pb = seed;
            sb = {seed[15:0], seed[31:16]};
            lb = ~seed;
            ab = seed ^ 32'h0F0F0F0F;
            seed = lfsr(seed);
            xi = {1'b0, seed[14:0]};
            yi = {1'b0, seed[30:16]};
            seed = lfsr(seed);
            d = {1'b0, seed[14:0]};
            b = k % 4 == 0 ? pb : k % 4 == 1 ? sb : k % 4 == 2 ? lb : ab;
            x = k / 4 == 1 ? 32'(yi) : k / 4 == 2 ? 32'(xi) : 32'h0;
            run(2'h2, vw1(1'b0, k / 4 == 2, k / 4 == 1, 2'(k)), d, 1'b0,
                exp_t'{b + 32'(d) + x, 1'b0, 1'b0});
        end
        $display("test bases done");
        xi = 16'hA;
        yi = 16'h6;
        for (int k = 0; k < 16; k++)
        begin
            c = 3'(k);
            seed = lfsr(seed);
            sb = seed;
            slow = k[0];
            lp = seed[9];
            ind = c[2] || c == 3'h3;
            x = c[1] ? 32'(xi) : 32'(yi);
            a = sb + 32'h2 + (c[2] && !c[0] ? x : 32'h0);
            b = ind ? ptr(a) + (c[2] && c[0] ? x : 32'h0)
                : sb + 32'h2 + (c == 3'h1 || c == 3'h2 ? x : 32'h0);
            if (ind && !(k > 7 && c != 3'h3))
            begin
                rd_q.push_back(a);
                rd_q.push_back(a + 32'h1);
            end
            run(2'h2, vw1(c[2], c[1], c[0], 2'h1), 16'h2, k[3],
                exp_t'{b, 1'b0, k > 7 && c != 3'h0 && c != 3'h3});
        end
        $display("test virtual done");
        seed = lfsr(seed);
        pc = seed[15:0];
        slow = 1'b1;
        run(2'h0, sw1(1'b0, 1'b0, 1'b0, 9'h005), 16'h0, 1'b0, exp_t'{32'h5, 1'b1, 1'b0});
        run(2'h0, sw1(1'b0, 1'b0, 1'b0, 9'h1A3), 16'h0, 1'b0, exp_t'{32'h1A3, 1'b0, 1'b0});
        run(2'h0, sw1(1'b0, 1'b0, 1'b1, 9'h0C5), 16'h0, 1'b0,
            exp_t'{{18'h0, pc[13:9], 9'h0C5}, 1'b0, 1'b0});
        rd_q.push_back(32'h2A);
        rd_q.push_back(32'h3A);
        run(2'h0, sw1(1'b1, 1'b1, 1'b0, 9'h020), 16'h0, 1'b0, exp_t'{32'h155, 1'b0, 1'b0});
        run(2'h1, sw1(1'b0, 1'b0, 1'b0, 9'h003), 16'h0, 1'b0, exp_t'{32'h3, 1'b1, 1'b0});
        run(2'h1, sw1(1'b0, 1'b0, 1'b1, 9'h0C5), 16'h0, 1'b0,
            exp_t'{{17'h0, pc[14:9], 9'h0C5}, 1'b0, 1'b0});
        run(2'h3, sw1(1'b0, 1'b1, 1'b0, 9'h0C5), 16'h0, 1'b0,
            exp_t'{32'hCF, 1'b0, 1'b0});
        rd_q.push_back(32'h49);
        run(2'h1, sw1(1'b1, 1'b1, 1'b0, 9'h03F), 16'h0, 1'b0, exp_t'{32'h123, 1'b0, 1'b0});
        rd_q.push_back(32'h40);
        run(2'h1, sw1(1'b1, 1'b1, 1'b0, 9'h040), 16'h0, 1'b0, exp_t'{32'h15A, 1'b0, 1'b0});
        rd_q.push_back(32'h44);
        rd_q.push_back(32'h46);
        run(2'h1, sw1(1'b1, 1'b0, 1'b0, 9'h044), 16'h0, 1'b0, exp_t'{32'h77, 1'b0, 1'b0});
        check(exp_q.size() == 0 && rd_q.size() == 0, "notes left over");
        $display("test sectored done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
